// [verilog/iber_consts.svh]
`ifndef IBER_CONSTS_SVH
`define IBER_CONSTS_SVH

// Register addresses
`define IBER_A_CTRL       3'h0
`define IBER_A_STAT       3'h1
`define IBER_A_DATA       3'h2
`define IBER_A_OWN        3'h3
`define IBER_A_IRQS       3'h4
`define IBER_A_IRQM       3'h5

// Control bit positions
`define IBER_B_ACK        2
`define IBER_B_SI         3
`define IBER_B_STOP       4
`define IBER_B_START      5

// Interrupt status bit positions
`define IBER_I_EVENT      0
`define IBER_I_BUSERR     1
`define IBER_I_ARB        2

// Reset values
`define IBER_RST_OWN      8'h00
`define IBER_RST_MASK     3'h0

// Timing
`define IBER_CLK_NS       50
`define IBER_HALF_NS      5000

// State codes
`define IBER_C_IDLE       8'hF8
`define IBER_C_BUSERR     8'h00
`define IBER_C_START      8'h08
`define IBER_C_RSTART     8'h10
`define IBER_C_MT_SLA_ACK 8'h18
`define IBER_C_MT_SLA_NAK 8'h20
`define IBER_C_MT_DATA_ACK 8'h28
`define IBER_C_MT_DATA_NAK 8'h30
`define IBER_C_ARB_LOST   8'h38
`define IBER_C_MR_SLA_ACK 8'h40
`define IBER_C_MR_SLA_NAK 8'h48
`define IBER_C_MR_DATA_ACK 8'h50
`define IBER_C_MR_DATA_NAK 8'h58
`define IBER_C_SR_SLA     8'h60
`define IBER_C_SR_ARB_SLA 8'h68
`define IBER_C_SR_GC      8'h70
`define IBER_C_SR_ARB_GC  8'h78
`define IBER_C_SR_DATA_ACK 8'h80
`define IBER_C_SR_DATA_NAK 8'h88
`define IBER_C_SR_GC_ACK  8'h90
`define IBER_C_SR_GC_NAK  8'h98
`define IBER_C_SR_STOP    8'hA0
`define IBER_C_ST_SLA     8'hA8
`define IBER_C_ST_ARB_SLA 8'hB0
`define IBER_C_ST_DATA_ACK 8'hB8
`define IBER_C_ST_DATA_NAK 8'hC0
`define IBER_C_ST_LAST    8'hC8

`endif

// [verilog/iber_pkg.sv]
package iber_pkg;

	typedef enum logic [3:0] {
		ST_IDLE      = 4'h0,
		ST_GEN_START = 4'h1,
		ST_MST_LOW   = 4'h2,
		ST_MST_HIGH  = 4'h3,
		ST_MST_HOLD  = 4'h4,
		ST_RSTA_LOW  = 4'h5,
		ST_RSTA_HIGH = 4'h6,
		ST_STOP_LOW  = 4'h7,
		ST_STOP_HIGH = 4'h8,
		ST_SLV       = 4'h9,
		ST_SLV_HOLD  = 4'hA
	} iber_state_t;

	typedef struct packed {
		iber_state_t st;
		logic [15:0] div;
		logic [3:0]  bitCnt;
		logic [7:0]  shift;
		logic [7:0]  code;
		logic [7:0]  ownAdr;
		logic [2:0]  irqStat;
		logic [2:0]  irqMask;
		logic [7:0]  rdData;
		logic        startReq;
		logic        stopReq;
		logic        si;
		logic        ackEn;
		logic        busy;
		logic        isRead;
		logic        addrPhase;
		logic        gc;
		logic        arbLost;
		logic        lastAck;
		logic        slvLast;
		logic        irq;
		logic        sclOeN;
		logic        sdaOeN;
		logic        sclS1;
		logic        sclS2;
		logic        sdaS1;
		logic        sdaS2;
		logic        sclPrev;
		logic        sdaPrev;
	} iber_regs_t;

endpackage : iber_pkg

// [verilog/iber_ctrl.sv]
`timescale 1ns/1ps
`include "iber_consts.svh"

module iber_ctrl
	import iber_pkg::*;
#(
	parameter int HALF = `IBER_HALF_NS / `IBER_CLK_NS
)(
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic [2:0] addr,
	input  wire logic [7:0] wrData,
	input  wire logic       wrStb,
	input  wire logic       rdStb,
	output logic [7:0]      rdData,
	output logic            irq,
	input  wire logic       sclIn,
	output logic            sclOut,
	output logic            sclOeN,
	input  wire logic       sdaIn,
	output logic            sdaOut,
	output logic            sdaOeN
);

	localparam logic [15:0] HALF_C = 16'(HALF);
	localparam logic [15:0] MID_C  = 16'(HALF / 2);

	iber_regs_t s;
	iber_regs_t n;
	logic       sclRise;
	logic       sclFall;
	logic       startDet;
	logic       stopDet;
	logic       ourCond;
	logic       involved;
	logic       busErr;
	logic       badSt;
	logic       mTx;
	logic       sTx;
	logic       match;
	logic       wrCtrl;

	// High means pull SDA low for bit b of the current byte
	function automatic logic wantLow(input logic tx, input logic [3:0] b,
		input logic [7:0] sh, input logic ack);
		if (b < 4'h8)
			return tx & ~sh[7];
		return ~tx & ack;
	endfunction : wantLow

	assign sclRise  = s.sclS2 & ~s.sclPrev;
	assign sclFall  = ~s.sclS2 & s.sclPrev;
	assign startDet = s.sclS2 & s.sclPrev & s.sdaPrev & ~s.sdaS2;
	assign stopDet  = s.sclS2 & s.sclPrev & ~s.sdaPrev & s.sdaS2;
	// Our own condition: we hold SDA low, or we are releasing it for STOP
	assign ourCond  = ~s.sdaOeN | (s.st == ST_STOP_HIGH);
	assign involved = (s.st != ST_IDLE) && (s.st != ST_GEN_START);
	// First bit slot is where legal START/STOP live
	assign busErr   = (startDet | stopDet) & involved & ~ourCond
		& (s.bitCnt >= 4'h2);
	assign mTx      = s.addrPhase | ~s.isRead;
	assign sTx      = s.isRead & ~s.addrPhase;
	assign match    = s.ackEn & ((s.shift[7:1] == s.ownAdr[7:1])
		| ((s.shift[7:1] == 7'h00) & s.ownAdr[0]));
	assign wrCtrl   = wrStb && (addr == `IBER_A_CTRL);

	// No stuck-bus timer here; a system timer must watch the lines
	always_comb begin
		n = s;
		badSt = 1'b0;
		n.sclS1 = sclIn;
		n.sclS2 = s.sclS1;
		n.sdaS1 = sdaIn;
		n.sdaS2 = s.sdaS1;
		n.sclPrev = s.sclS2;
		n.sdaPrev = s.sdaS2;
		n.rdData = 8'h00;
		// Clear first so that a hardware set below wins
		if (wrCtrl && !wrData[`IBER_B_SI])
			n.si = 1'b0;
		if (wrStb && (addr == `IBER_A_IRQS))
			n.irqStat = s.irqStat & ~wrData[2:0];
		if (s.div != 16'h0000)
			n.div = s.div - 16'h0001;
		if (startDet) begin
			n.busy = 1'b1;
			n.bitCnt = 4'h0;
			n.addrPhase = 1'b1;
		end
		if (stopDet) begin
			n.busy = 1'b0;
			n.bitCnt = 4'h0;
		end
		if (sclRise) begin
			n.shift = {s.shift[6:0], s.sdaS2};
			if (s.bitCnt != 4'h9)
				n.bitCnt = s.bitCnt + 4'h1;
			if (s.bitCnt == 4'h8)
				n.lastAck = ~s.sdaS2;
		end

		unique case (s.st)
		ST_IDLE: begin
			n.sclOeN = 1'b1;
			n.sdaOeN = 1'b1;
			if (sclFall && (s.bitCnt == 4'h9))
				n.bitCnt = 4'h0;
			if (sclFall && (s.bitCnt == 4'h8) && s.addrPhase) begin
				n.addrPhase = 1'b0;
				if (match) begin
					n.st = ST_SLV;
					n.div = 16'h0000;
					n.gc = (s.shift[7:1] == 7'h00);
					n.isRead = s.shift[0];
					n.addrPhase = 1'b1;
					n.sdaOeN = 1'b0;
				end else if (s.arbLost) begin
					n.arbLost = 1'b0;
					n.si = 1'b1;
					n.code = `IBER_C_ARB_LOST;
				end
			end
			if (s.startReq && s.stopReq) begin
				// Forced access: pretend a STOP was seen
				n.stopReq = 1'b0;
				n.busy = 1'b0;
			end else if (s.stopReq && !s.startReq && !s.si) begin
				n.stopReq = 1'b0;
			end else if (s.startReq && !s.si && !s.busy) begin
				n.st = ST_GEN_START;
				n.div = HALF_C;
			end
		end
		ST_GEN_START: begin
			n.sclOeN = 1'b1;
			if (s.sdaOeN && s.busy) begin
				n.st = ST_IDLE;
			end else if (s.div == 16'h0000) begin
				n.div = HALF_C;
				if (s.sdaOeN) begin
					n.sdaOeN = 1'b0;
				end else begin
					n.sclOeN = 1'b0;
					n.si = 1'b1;
					n.code = `IBER_C_START;
					n.st = ST_MST_HOLD;
				end
			end
		end
		ST_MST_HOLD: begin
			n.sclOeN = 1'b0;
			if (!s.si) begin
				n.div = HALF_C;
				if (s.addrPhase)
					n.isRead = s.shift[0];
				if (s.stopReq) begin
					n.st = ST_STOP_LOW;
					n.sdaOeN = 1'b0;
				end else if (s.startReq) begin
					n.st = ST_RSTA_LOW;
					n.sdaOeN = 1'b1;
				end else begin
					n.st = ST_MST_LOW;
				end
			end
		end
		ST_MST_LOW: begin
			n.sclOeN = 1'b0;
			if (s.div == MID_C)
				n.sdaOeN = ~wantLow(mTx, s.bitCnt, s.shift, s.ackEn);
			if (s.div == 16'h0000) begin
				n.st = ST_MST_HIGH;
				n.sclOeN = 1'b1;
				n.div = HALF_C;
			end
		end
		ST_MST_HIGH: begin
			n.sclOeN = 1'b1;
			if (!s.sclS2)
				n.div = HALF_C;
			// Lost only when we released SDA and read it low
			if (sclRise && mTx && (s.bitCnt < 4'h8)
				&& s.sdaOeN && !s.sdaS2) begin
				n.st = ST_IDLE;
				n.sdaOeN = 1'b1;
				n.irqStat[`IBER_I_ARB] = 1'b1;
				if (s.addrPhase) begin
					n.arbLost = 1'b1;
				end else begin
					n.si = 1'b1;
					n.code = `IBER_C_ARB_LOST;
				end
			end else if (s.sclS2 && (s.div == 16'h0000)) begin
				n.sclOeN = 1'b0;
				n.div = HALF_C;
				if (s.bitCnt == 4'h9) begin
					n.st = ST_MST_HOLD;
					n.si = 1'b1;
					n.bitCnt = 4'h0;
					n.addrPhase = 1'b0;
					if (s.addrPhase && s.isRead)
						n.code = s.lastAck ? `IBER_C_MR_SLA_ACK
							: `IBER_C_MR_SLA_NAK;
					else if (s.addrPhase)
						n.code = s.lastAck ? `IBER_C_MT_SLA_ACK
							: `IBER_C_MT_SLA_NAK;
					else if (s.isRead)
						n.code = s.lastAck ? `IBER_C_MR_DATA_ACK
							: `IBER_C_MR_DATA_NAK;
					else
						n.code = s.lastAck ? `IBER_C_MT_DATA_ACK
							: `IBER_C_MT_DATA_NAK;
				end else begin
					n.st = ST_MST_LOW;
				end
			end
		end
		ST_RSTA_LOW: begin
			n.sclOeN = 1'b0;
			n.sdaOeN = 1'b1;
			if (s.div == 16'h0000) begin
				n.st = ST_RSTA_HIGH;
				n.sclOeN = 1'b1;
				n.div = HALF_C;
			end
		end
		ST_RSTA_HIGH: begin
			n.sclOeN = 1'b1;
			if (!s.sclS2)
				n.div = HALF_C;
			if (startDet && s.sdaOeN) begin
				// Another master got its repeated START out first
				n.st = ST_IDLE;
			end else if (s.div == 16'h0000) begin
				n.div = HALF_C;
				if (s.sdaOeN) begin
					n.sdaOeN = 1'b0;
				end else begin
					n.sclOeN = 1'b0;
					n.si = 1'b1;
					n.code = `IBER_C_RSTART;
					n.st = ST_MST_HOLD;
				end
			end
		end
		ST_STOP_LOW: begin
			n.sclOeN = 1'b0;
			n.sdaOeN = 1'b0;
			if (s.div == 16'h0000) begin
				n.st = ST_STOP_HIGH;
				n.sclOeN = 1'b1;
				n.div = HALF_C;
			end
		end
		ST_STOP_HIGH: begin
			n.sclOeN = 1'b1;
			if (!s.sclS2)
				n.div = HALF_C;
			if (s.div == 16'h0000) begin
				n.div = HALF_C;
				if (!s.sdaOeN) begin
					n.sdaOeN = 1'b1;
				end else begin
					n.st = ST_IDLE;
					n.stopReq = 1'b0;
				end
			end
		end
		ST_SLV: begin
			// Keep SCL low until the data setup time has passed
			if (s.div == 16'h0000)
				n.sclOeN = 1'b1;
			if ((startDet || stopDet) && !busErr) begin
				n.st = ST_IDLE;
				n.sdaOeN = 1'b1;
				if (!s.isRead) begin
					n.si = 1'b1;
					n.code = `IBER_C_SR_STOP;
				end
			end else if (sclFall && (s.bitCnt == 4'h9)) begin
				n.st = ST_SLV_HOLD;
				n.si = 1'b1;
				n.bitCnt = 4'h0;
				n.addrPhase = 1'b0;
				n.arbLost = 1'b0;
				n.sclOeN = 1'b0;
				n.sdaOeN = 1'b1;
				n.slvLast = ~s.lastAck;
				if (s.addrPhase) begin
					n.slvLast = 1'b0;
					if (s.isRead)
						n.code = s.arbLost ? `IBER_C_ST_ARB_SLA
							: `IBER_C_ST_SLA;
					else if (s.gc)
						n.code = s.arbLost ? `IBER_C_SR_ARB_GC
							: `IBER_C_SR_GC;
					else
						n.code = s.arbLost ? `IBER_C_SR_ARB_SLA
							: `IBER_C_SR_SLA;
				end else if (s.isRead) begin
					n.slvLast = ~s.lastAck | ~s.ackEn;
					n.code = !s.lastAck ? `IBER_C_ST_DATA_NAK
						: (s.ackEn ? `IBER_C_ST_DATA_ACK
						: `IBER_C_ST_LAST);
				end else if (s.gc) begin
					n.code = s.lastAck ? `IBER_C_SR_GC_ACK
						: `IBER_C_SR_GC_NAK;
				end else begin
					n.code = s.lastAck ? `IBER_C_SR_DATA_ACK
						: `IBER_C_SR_DATA_NAK;
				end
			end else if (sclFall) begin
				n.sdaOeN = ~wantLow(sTx, s.bitCnt, s.shift, s.ackEn);
			end
		end
		ST_SLV_HOLD: begin
			n.sclOeN = 1'b0;
			if (!s.si) begin
				if (s.slvLast) begin
					n.st = ST_IDLE;
					n.sclOeN = 1'b1;
				end else begin
					n.st = ST_SLV;
					n.div = HALF_C;
					n.sdaOeN = ~wantLow(sTx, 4'h0, s.shift, s.ackEn);
				end
			end
		end
		default: begin
			badSt = 1'b1;
		end
		endcase

		if (busErr || badSt) begin
			n.st = ST_IDLE;
			n.sclOeN = 1'b1;
			n.sdaOeN = 1'b1;
			n.si = 1'b1;
			n.code = `IBER_C_BUSERR;
			n.arbLost = 1'b0;
			n.irqStat[`IBER_I_BUSERR] = 1'b1;
		end
		if (n.si && !s.si)
			n.irqStat[`IBER_I_EVENT] = 1'b1;

		// Software writes last: a fresh request beats a hardware clear
		if (wrCtrl) begin
			n.ackEn = wrData[`IBER_B_ACK];
			n.startReq = wrData[`IBER_B_START];
			n.stopReq = wrData[`IBER_B_STOP];
		end
		if (wrStb && (addr == `IBER_A_DATA))
			n.shift = wrData;
		if (wrStb && (addr == `IBER_A_OWN))
			n.ownAdr = wrData;
		if (wrStb && (addr == `IBER_A_IRQM))
			n.irqMask = wrData[2:0];
		n.irq = |(n.irqStat & n.irqMask);

		if (rdStb) begin
			unique case (addr)
			`IBER_A_CTRL: begin
				n.rdData[`IBER_B_ACK] = s.ackEn;
				n.rdData[`IBER_B_SI] = s.si;
				n.rdData[`IBER_B_STOP] = s.stopReq;
				n.rdData[`IBER_B_START] = s.startReq;
			end
			`IBER_A_STAT: n.rdData = s.si ? s.code : `IBER_C_IDLE;
			`IBER_A_DATA: n.rdData = s.shift;
			`IBER_A_OWN:  n.rdData = s.ownAdr;
			`IBER_A_IRQS: n.rdData = {5'h00, s.irqStat};
			`IBER_A_IRQM: n.rdData = {5'h00, s.irqMask};
			default:      n.rdData = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			s <= '0;
			s.st <= ST_IDLE;
			s.code <= `IBER_C_IDLE;
			s.ownAdr <= `IBER_RST_OWN;
			s.irqMask <= `IBER_RST_MASK;
			s.sclOeN <= 1'b1;
			s.sdaOeN <= 1'b1;
			s.sclS1 <= 1'b1;
			s.sclS2 <= 1'b1;
			s.sdaS1 <= 1'b1;
			s.sdaS2 <= 1'b1;
			s.sclPrev <= 1'b1;
			s.sdaPrev <= 1'b1;
		end else begin
			s <= n;
		end
	end

	// Open drain: the pin only ever pulls low
	assign sclOut = 1'b0;
	assign sdaOut = 1'b0;
	assign sclOeN = s.sclOeN;
	assign sdaOeN = s.sdaOeN;
	assign rdData = s.rdData;
	assign irq    = s.irq;

endmodule : iber_ctrl

// [testbench/iber_ctrl_asserts.sv]
`timescale 1ns/1ps
module iber_ctrl_chk #(
	parameter int HALF = 100
)(
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic [2:0] addr,
	input  wire logic [7:0] wrData,
	input  wire logic       wrStb,
	input  wire logic       rdStb,
	input  wire logic [7:0] rdData,
	input  wire logic       irq,
	input  wire logic       sclIn,
	input  wire logic       sclOut,
	input  wire logic       sclOeN,
	input  wire logic       sdaIn,
	input  wire logic       sdaOut,
	input  wire logic       sdaOeN
);
	logic [2:0] mask;

	always_ff @(posedge clock) begin
		if (rst)
			mask <= 3'h0;
		else if (wrStb && addr == 3'h5)
			mask <= wrData[2:0];
	end

	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	read_idle_a: assert property (!$past(rdStb) |-> rdData == 8'h00)
		else $error("read data outside a read");
	read_unmapped_a: assert property (rdStb && addr[2:1] == 2'b11
		|=> rdData == 8'h00)
		else $error("unmapped read not zero");
	own_readback_a: assert property (wrStb && addr == 3'h3
		##1 rdStb && addr == 3'h3 |=> rdData == $past(wrData, 2))
		else $error("own address readback");
	mask_readback_a: assert property (wrStb && addr == 3'h5
		##1 rdStb && addr == 3'h5 |=> rdData[2:0] == $past(wrData[2:0], 2))
		else $error("mask readback");
	irq_masked_a: assert property (mask == 3'h0 && $past(mask) == 3'h0
		|-> !irq)
		else $error("interrupt while fully masked");
	open_drain_a: assert property (sclOut == 1'b0 && sdaOut == 1'b0)
		else $error("line driven high");
	buserr_release_a: assert property (
		rdStb && addr == 3'h1 ##1 rdData == 8'h00 |-> sclOeN && sdaOeN)
		else $error("lines held after bus error");
	held_clock_a: assert property (
		rdStb && addr == 3'h1 ##1 (rdData == 8'h60 || rdData == 8'h08)
		|-> !sclOeN)
		else $error("clock not held while event pending");
	recover_stop_a: assert property (
		wrStb && addr == 3'h0 && wrData[5:3] == 3'b010
		##2 rdStb && addr == 3'h0 |=> !rdData[4])
		else $error("stop flag left after recovery");
	forced_stop_a: assert property (
		wrStb && addr == 3'h0 && wrData[5:4] == 2'b11
		##2 rdStb && addr == 3'h0 |=> !rdData[4] && rdData[5])
		else $error("stop flag left after forced access");
endmodule : iber_ctrl_chk

bind iber_ctrl iber_ctrl_chk #(.HALF(HALF)) chk (
	.clock(clock), .rst(rst), .addr(addr), .wrData(wrData),
	.wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .irq(irq),
	.sclIn(sclIn), .sclOut(sclOut), .sclOeN(sclOeN),
	.sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOeN(sdaOeN)
);

// [testbench/iber_peer.sv]
`timescale 1ns/1ps
module iber_peer (
	input  wire logic clock,
	output logic      sclOeN,
	output logic      sdaOeN
);
	initial begin
		sclOeN = 1'b1;
		sdaOeN = 1'b1;
	end

	// Half of a 400 ns link period; no stretch wait, so callers must
	// service the block before driving on
	task automatic step(input logic c, input logic d);
		repeat (4) @(posedge clock);
		sclOeN <= c;
		sdaOeN <= d;
	endtask : step

	// Also the resync START after a stuck data line
	task automatic start();
		step(1'b1, 1'b1);
		step(1'b1, 1'b0);
		step(1'b0, 1'b0);
	endtask : start

	task automatic stop();
		step(1'b0, 1'b0);
		step(1'b1, 1'b0);
		step(1'b1, 1'b1);
	endtask : stop

	task automatic bits(input logic [7:0] b, input int n);
		for (int i = 7; i > 7 - n; i--) begin
			step(1'b0, b[i]);
			step(1'b1, b[i]);
		end
	endtask : bits
endmodule : iber_peer

// [testbench/iber_ctrl_tb.sv]
`timescale 1ns/1ps
module iber_ctrl_tb;
	typedef struct packed {
		logic       wr;
		logic [2:0] a;
		logic [7:0] d;
	} iber_row_t;

	logic       clock = 1'b0;
	logic       rst = 1'b1;
	logic [2:0] addr = 3'h0;
	logic [7:0] wrData = 8'h00;
	logic       wrStb = 1'b0;
	logic       rdStb = 1'b0;
	logic [7:0] rdData;
	logic       irq;
	logic       sclOeN;
	logic       sdaOeN;
	logic       pScl;
	logic       pSda;
	wire        sclBus = sclOeN & pScl;
	wire        sdaBus = sdaOeN & pSda;
	int         miscompares = 0;
	int         totalChecks = 0;
	int         cycles = 0;
	iber_row_t  rows [9];
	logic [7:0] v;

	always #25 clock = ~clock;

	iber_ctrl #(.HALF(8)) uut (
		.clock(clock), .rst(rst), .addr(addr), .wrData(wrData),
		.wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .irq(irq),
		.sclIn(sclBus), .sclOut(), .sclOeN(sclOeN),
		.sdaIn(sdaBus), .sdaOut(), .sdaOeN(sdaOeN)
	);

	iber_peer peer (.clock(clock), .sclOeN(pScl), .sdaOeN(pSda));

	task automatic stop_test();
		if (miscompares == 0 && totalChecks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : stop_test

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		addr <= a;
		wrData <= d;
		wrStb <= 1'b1;
		@(posedge clock);
		wrStb <= 1'b0;
	endtask : wr

	task automatic rd(input logic [2:0] a, output logic [7:0] q);
		addr <= a;
		rdStb <= 1'b1;
		@(posedge clock);
		rdStb <= 1'b0;
		@(negedge clock);
		q = rdData;
		@(posedge clock);
	endtask : rd

	task automatic waitIrq();
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 600) begin
			@(posedge clock);
			n++;
		end
		chk({7'h00, irq}, 8'h01);
	endtask : waitIrq

	// Address byte from the far master, ack slot sampled mid-high
	task automatic sendAdr(input logic [7:0] b, input logic ackLvl);
		peer.start();
		peer.bits(b, 8);
		peer.step(1'b0, 1'b1);
		peer.step(1'b1, 1'b1);
		repeat (2) @(posedge clock);
		chk({7'h00, sdaBus}, {7'h00, ackLvl});
		peer.step(1'b0, 1'b1);
	endtask : sendAdr

	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			miscompares++;
			stop_test();
		end
	end

	initial begin
		rows = '{'{1'b0, 3'h3, 8'h00}, '{1'b1, 3'h3, 8'hA4},
			'{1'b0, 3'h3, 8'hA4}, '{1'b1, 3'h5, 8'h07},
			'{1'b0, 3'h5, 8'h07}, '{1'b0, 3'h6, 8'h00},
			'{1'b0, 3'h7, 8'h00}, '{1'b0, 3'h1, 8'hF8},
			'{1'b0, 3'h0, 8'h00}};
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		chk({6'h00, sclOeN, sdaOeN}, 8'h03);
		for (int i = 0; i < 9; i++) begin
			if (rows[i].wr)
				wr(rows[i].a, rows[i].d);
			else begin
				rd(rows[i].a, v);
				chk(v, rows[i].d);
			end
		end
		// Acknowledge flag clear: address ignored, bad STOP not ours
		sendAdr(8'hA4, 1'b1);
		peer.bits(8'h40, 3);
		peer.stop();
		repeat (8) @(posedge clock);
		rd(3'h1, v);
		chk(v, 8'hF8);
		chk({7'h00, irq}, 8'h00);
		wr(3'h0, 8'h04);
		sendAdr(8'hA4, 1'b0);
		waitIrq();
		rd(3'h1, v);
		chk(v, 8'h60);
		chk({7'h00, sclOeN}, 8'h00);
		wr(3'h4, 8'h07);
		@(posedge clock);
		wr(3'h0, 8'h04);
		chk({7'h00, irq}, 8'h00);
		peer.bits(8'h40, 3);
		peer.stop();
		waitIrq();
		rd(3'h1, v);
		chk(v, 8'h00);
		chk({6'h00, sclOeN, sdaOeN}, 8'h03);
		wr(3'h0, 8'h14);
		@(posedge clock);
		rd(3'h0, v);
		chk(v, 8'h04);
		rd(3'h1, v);
		chk(v, 8'hF8);
		// Dangling START leaves the bus busy until a forced access
		wr(3'h4, 8'h07);
		peer.start();
		peer.step(1'b0, 1'b1);
		peer.step(1'b1, 1'b1);
		wr(3'h0, 8'h24);
		repeat (60) @(posedge clock);
		chk({7'h00, irq}, 8'h00);
		wr(3'h0, 8'h34);
		@(posedge clock);
		rd(3'h0, v);
		chk(v, 8'h24);
		waitIrq();
		rd(3'h1, v);
		chk(v, 8'h08);
		chk({7'h00, sclOeN}, 8'h00);
		wr(3'h0, 8'h14);
		repeat (60) @(posedge clock);
		chk({6'h00, sclOeN, sdaOeN}, 8'h03);
		rd(3'h1, v);
		chk(v, 8'hF8);
		stop_test();
	end
endmodule : iber_ctrl_tb
